// ==== hv_startup_pkg.sv ====
// Constants and carrier types for the high-voltage start-up interlock.
package hv_startup_pkg;

  localparam int clk_hz = 20_000_000;
  localparam int delay_w = 32;
  localparam int default_delay_ms = 15000;
  localparam logic [delay_w-1:0] default_delay_cycles = delay_w'(64'(default_delay_ms) * 64'(clk_hz) / 64'd1000);
  localparam logic [delay_w-1:0] delay_count_reset = 32'h0000_0000;
  localparam int switch_count = 8;
  localparam logic [2:0] default_insulation_switch = 3'h1;

  typedef enum logic [1:0] {
    resp_raw = 2'b00,
    resp_filtered = 2'b01,
    resp_ignore = 2'b10
  } response_mode_t;

  typedef struct packed {
    logic interlock_loop_state;
    logic min_cell_voltage_fault;
    logic ignition_on;
  } pack_inputs_t;

  typedef struct packed {
    logic insulation_raw_level;
    logic insulation_qualified_level;
    logic insulation_fault_latch;
    logic pack_ready;
    logic precharge_permit;
    logic contactor_permit;
  } pack_status_t;

endpackage

// ==== startup_delay_timer.sv ====
// Startup delay counter that reports when the qualifying delay has elapsed.
`timescale 1ns/1ps
`default_nettype none
module startup_delay_timer
  import hv_startup_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [hv_startup_pkg::delay_w-1:0] delay_cycles,
  output logic expired
);
  logic [delay_w-1:0] count_reg;
  logic expired_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= delay_count_reset;
      expired_reg <= 1'b0;
    end else if (!expired_reg) begin
      if (count_reg >= delay_cycles) begin
        expired_reg <= 1'b1;
      end else begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  assign expired = expired_reg;

  delay_latched_a: assert property (@(posedge clk) disable iff (!rst_n)
    expired_reg |=> expired_reg) else $error("Expired flag dropped.");
endmodule // startup_delay_timer
`default_nettype wire

// ==== hv_startup_interlock.sv ====
// Start-up qualification of the high-voltage pack from insulation, interlock and cell inputs.
`timescale 1ns/1ps
`default_nettype none
module hv_startup_interlock
  import hv_startup_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [hv_startup_pkg::switch_count-1:0] digital_switch_inputs,
  input wire logic [2:0] insulation_switch_select,
  input wire logic [hv_startup_pkg::delay_w-1:0] insulation_startup_delay,
  input wire hv_startup_pkg::response_mode_t insulation_response_select,
  input wire logic insulation_latch_clear,
  input wire hv_startup_pkg::pack_inputs_t pack_inputs,
  output hv_startup_pkg::pack_status_t pack_status
);
  import hv_startup_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser.
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Insulation input selection and qualification.
  logic raw_level;
  logic timer_expired;
  logic raw_reg;
  logic qualified_reg;
  logic latch_reg;
  logic selected_fault;
  logic ready_reg;
  logic contactor_reg;

  assign raw_level = digital_switch_inputs[insulation_switch_select];

  startup_delay_timer u_timer (
    .clk(clk),
    .rst_n(rst_sync_reg),
    .delay_cycles(insulation_startup_delay),
    .expired(timer_expired)
  );

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      raw_reg <= 1'b0;
    end else begin
      raw_reg <= raw_level;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      qualified_reg <= 1'b0;
    end else if (timer_expired) begin
      qualified_reg <= raw_level;
    end
  end

  // Set wins over clear so a fault in the clear cycle is kept.
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      latch_reg <= 1'b0;
    end else if (selected_fault) begin
      latch_reg <= 1'b1;
    end else if (insulation_latch_clear) begin
      latch_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pack ready and contactor permit.
  always_comb begin
    unique case (insulation_response_select)
      resp_raw: selected_fault = raw_level;
      resp_filtered: selected_fault = timer_expired && raw_level;
      resp_ignore: selected_fault = 1'b0;
      default: selected_fault = raw_level;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= pack_inputs.interlock_loop_state
        && !pack_inputs.min_cell_voltage_fault
        && !selected_fault;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      contactor_reg <= 1'b0;
    end else begin
      contactor_reg <= ready_reg && pack_inputs.ignition_on;
    end
  end

  always_comb begin
    pack_status.insulation_raw_level = raw_reg;
    pack_status.insulation_qualified_level = qualified_reg;
    pack_status.insulation_fault_latch = latch_reg;
    pack_status.pack_ready = ready_reg;
    pack_status.precharge_permit = ready_reg;
    pack_status.contactor_permit = contactor_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  qual_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    !timer_expired |=> $stable(qualified_reg)) else $error("Qualified level moved early.");
  raw_follow_a: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    1'b1 |=> raw_reg == $past(raw_level)) else $error("Raw level wrong.");
  latch_sticky_a: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    latch_reg && !insulation_latch_clear |=> latch_reg) else $error("Latch lost.");
  latch_set_a: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    selected_fault |=> latch_reg) else $error("Fault not latched.");
  precharge_block_a: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    !ready_reg |-> !pack_status.precharge_permit) else $error("Pre-charge allowed.");
  loop_open_a: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    !pack_inputs.interlock_loop_state |=> !ready_reg) else $error("Ready with open loop.");
  cell_fault_a: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    pack_inputs.min_cell_voltage_fault |=> !ready_reg) else $error("Ready with cell fault.");
  ignore_mode_a: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    insulation_response_select == resp_ignore && pack_inputs.interlock_loop_state
    && !pack_inputs.min_cell_voltage_fault |=> ready_reg) else $error("Ignore mode not ready.");
  raw_fault_a: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    insulation_response_select == resp_raw && raw_level |=> !ready_reg) else $error("Raw fault ignored.");
  contactor_a: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    contactor_reg |-> $past(ready_reg) && $past(pack_inputs.ignition_on)) else $error("Contactor wrong.");
endmodule // hv_startup_interlock
`default_nettype wire

// ==== hv_source_model.sv ====
// Far-side model of the insulation monitor, interlock loop and ignition switch.
`timescale 1ns/1ps
`default_nettype none
module hv_source_model (
  input wire logic [4:0] stim,
  output logic [hv_startup_pkg::switch_count-1:0] switches,
  output hv_startup_pkg::pack_inputs_t pack_inputs
);
  import hv_startup_pkg::*;
  // The monitor fault sits on switch one; stray levels on its neighbours.
  assign switches = {5'h00, stim[3], stim[4], stim[3]};
  assign pack_inputs = '{interlock_loop_state: stim[2], min_cell_voltage_fault: stim[1], ignition_on: stim[0]};
endmodule // hv_source_model
`default_nettype wire

// ==== hv_startup_interlock_tb_top.sv ====
// Self-checking testbench for the high-voltage start-up interlock.
`timescale 1ns/1ps
`default_nettype none
module hv_startup_interlock_tb_top;
  import hv_startup_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] stim = 6'h00;
  response_mode_t mode = resp_ignore;
  pack_status_t status;
  logic [7:0] switches;
  pack_inputs_t pins;
  int bad_count = 0;
  int checks = 0;
  ////////////////////////////////////////////////////////////
  always #25 clk = ~clk;
  hv_source_model u_hv_source_model (.stim(stim[4:0]), .switches(switches), .pack_inputs(pins));
  hv_startup_interlock u_hv_startup_interlock (
    .clk(clk),
    .rst_n(rst_n),
    .digital_switch_inputs(switches),
    .insulation_switch_select(default_insulation_switch),
    .insulation_startup_delay(32'h0000_0014),
    .insulation_response_select(mode),
    .insulation_latch_clear(stim[5]),
    .pack_inputs(pins),
    .pack_status(status)
  );
  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Stim is clear, fault, stray, loop, cell, ignition; status order as the struct.
  task automatic step(input logic [5:0] s, input response_mode_t m, input logic [5:0] exp);
    stim = s;
    mode = m;
    repeat (3) @(negedge clk);
    checks++;
    if (status !== exp) begin
      bad_count++;
      $display("mismatch pack_status expected %h seen %h", exp, status);
    end
    $display("test done stim %h", s);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    step(6'h0d, resp_filtered, 6'h07);
    step(6'h15, resp_filtered, 6'h27);
    step(6'h15, resp_raw, 6'h28);
    step(6'h05, resp_raw, 6'h0f);
    step(6'h25, resp_raw, 6'h07);
    step(6'h01, resp_raw, 6'h00);
    step(6'h07, resp_raw, 6'h00);
    step(6'h04, resp_raw, 6'h06);
    step(6'h15, resp_ignore, 6'h37);
    step(6'h15, resp_filtered, 6'h38);
    step(6'h15, response_mode_t'(2'b11), 6'h38);
    finish_test();
  end
endmodule // hv_startup_interlock_tb_top
`default_nettype wire
